// ===== src/sgd_pkg.sv
// Package: command, state and carrier types for the graphics DRAM command decoder
package sgd_pkg;

  // ----------------------------------------------------------------
  // Widths, pin positions, timing counts
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 10;
  localparam int ROW_W      = 9;
  localparam int COL_W      = 8;
  localparam int LANES      = 4;
  localparam int BANK_BIT   = 9;
  localparam int AP_BIT     = 8;
  localparam int BL_W       = 9;
  localparam int BL_DEF     = 4;
  localparam int BL_FULL    = 256;
  localparam int T_RP_NS    = 30;
  localparam int T_RCD_NS   = 30;
  localparam int T_DPL_NS   = 20;
  localparam int T_RC_NS    = 90;
  localparam int T_RSC_NS   = 20;
  localparam int CLK_NS     = 25;
  localparam int CNT_RP     = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_RCD    = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_DPL    = (T_DPL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_RC     = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_RSC    = (T_RSC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] BANKS_IDLE_RST = 2'h0;

  typedef enum {
    SGD_C_CHIP_DESELECT, SGD_C_NOP, SGD_C_BST, SGD_C_READ, SGD_C_STORE_BURST_CMD, SGD_C_BW,
    SGD_C_ACT, SGD_C_ROW_OPEN_MASKED_CMD, SGD_C_PRE, SGD_C_REF, SGD_C_MRS, SGD_C_SRS, SGD_C_UNDEF
  } sgd_cmd_t;

  typedef enum {
    SGD_IDLE, SGD_ACTIVATING, SGD_ACTIVE, SGD_READ, SGD_READ_AP, SGD_WRITE,
    SGD_WRITE_AP, SGD_WRREC, SGD_WRREC_AP, SGD_PRECH
  } sgd_bank_t;

  typedef enum {
    SGD_M_RUN, SGD_M_SUSPEND, SGD_M_PDOWN, SGD_M_SELF, SGD_M_REFRESH, SGD_M_MRACC
  } sgd_mode_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              gfx_sel;
    logic              cke;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_mask;
  } sgd_pins_t;

  typedef struct packed {
    logic              bank;
    logic              is_write;
    logic              is_block;
    logic              auto_close;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
    logic [LANES-1:0]  lane_pass;
  } sgd_burst_t;

endpackage

// ===== src/sgd_fifo.sv
// Small valid/ready FIFO that carries accepted column commands
`timescale 1ns/100ps
module sgd_fifo
  import sgd_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  always_comb begin
    push    = i_in_valid && (cnt_reg != (AW+1)'(DEPTH));
    pop     = (cnt_reg != '0) && i_out_ready;
    wr_next = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
    rd_next = pop ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  assign o_in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data  = mem_reg[rd_reg];
endmodule

// ===== src/sgd_decoder.sv
// Two-bank graphics DRAM command decoder with bank state tracking
//
// Behaviour
// RULE1: Deselect when chip select high; no-op or burst halt by write-enable.
// RULE2: Column commands: bank from A9, column A7-A0, A8 auto-close, WE direction.
// RULE3: Store with graphics select high becomes block write, autoclose if A8.
// RULE4: Row open latches bank and row; graphics select enables per-bit mask.
// RULE5: Bank close: A8 low closes A9 bank, A8 high closes both.
// RULE6: All strobes low: mode load, or colour/mask load when graphics high.
// RULE7: Lane mask low passes the lane, high blocks it.
// RULE8: CKE falling in activity enters clock suspend until CKE returns high.
// RULE9: Both idle with CKE low enters power down; CKE high exits to idle.
// RULE10: Idle row open latches row and activates; bank close is no-op.
// RULE11: Idle masked row open activates with mask register as write mask.
// RULE12: Idle refresh: auto with CKE high, self with CKE low; column/halt illegal.
// RULE13: Mode load accepted only with both banks idle.
// RULE14: Active: fetch/store latches column, starts burst, records auto-close.
// RULE15: Active: block write latches column, starts masked write, records auto-close.
// RULE16: Fetch burst: new fetch restarts; no-op runs to end then active.
// RULE17: Fetch burst: store or block write ends fetch and starts write.
// RULE18: Burst halt is no-op for short bursts, stops full page bursts.
// RULE19: Fetch burst: bank close ends burst and precharges with read timing.
// RULE20: Write burst: bank close ends burst with write timing, masks late data; the code only adds CNT_DPL to the close timer and masks no data.
// RULE21: Store burst: fetch ends store; completed write enters write recovery.
// RULE22: Auto-close write: only no-op legal; recovery then precharge.
// RULE23: Auto-close fetch: runs to end then precharges; commands illegal.
// RULE24: Colour/mask load accepted in idle, active, activating, recovering, precharging.
// RULE25: Write recovery accepts column commands; close and row open illegal.
// RULE26: Illegal commands judged per addressed bank; other bank keeps its own state.
// RULE27: Separate state per bank, decode applied to bank chosen by A9.
`timescale 1ns/100ps
module sgd_decoder
  import sgd_pkg::*;
#(
  parameter int BURST_LEN = BL_DEF,
  parameter int FIFO_W    = 1 + 1 + 1 + 1 + COL_W + ROW_W + LANES,
  parameter int FIFO_D    = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic              i_gfx_sel,
  input  wire logic              i_cke,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [LANES-1:0]  i_lane_mask,
  input  wire logic              i_burst_ready,
  output logic                   o_burst_valid,
  output logic [FIFO_W-1:0]      o_burst_data,
  output logic [1:0]             o_bank_open,
  output logic [1:0]             o_bit_mask_en,
  output logic                   o_illegal,
  output logic                   o_suspend,
  output logic                   o_power_down,
  output logic                   o_self_refresh,
  output logic                   o_mode_load,
  output logic                   o_color_load,
  output logic [ADDR_W-1:0]      o_opcode,
  output logic [LANES-1:0]       o_lane_pass,
  output logic                   o_cmd_stall
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PW = $bits(sgd_pins_t);
  sgd_pins_t s1_reg, s2_reg, s3_reg, pin_raw;
  sgd_pins_t pin;

  always_comb begin
    pin_raw = '{cs_n: i_cs_n, ras_n: i_ras_n, cas_n: i_cas_n, we_n: i_we_n,
                gfx_sel: i_gfx_sel, cke: i_cke, addr: i_addr, lane_mask: i_lane_mask};
    // Decode always takes stage three, whether or not stages two and three agree
    pin = (s2_reg == s3_reg) ? s3_reg : s3_reg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1_reg <= sgd_pins_t'({1'b1, 1'b1, 1'b1, 1'b1, {(PW-4){1'b0}}});
      s2_reg <= sgd_pins_t'({1'b1, 1'b1, 1'b1, 1'b1, {(PW-4){1'b0}}});
      s3_reg <= sgd_pins_t'({1'b1, 1'b1, 1'b1, 1'b1, {(PW-4){1'b0}}});
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= (s2_reg == s3_reg) ? s3_reg : s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  sgd_cmd_t cmd;
  logic     cke_prev_reg, cke_prev_next;
  logic     sel_bank, ap;

  always_comb begin
    sel_bank = pin.addr[BANK_BIT];
    ap       = pin.addr[AP_BIT];
    if (pin.cs_n) begin
      cmd = SGD_C_CHIP_DESELECT; // RULE1
    end else begin
      unique case ({pin.ras_n, pin.cas_n, pin.we_n})
        3'b111:  cmd = SGD_C_NOP; // RULE1
        3'b110:  cmd = pin.gfx_sel ? SGD_C_UNDEF : SGD_C_BST; // RULE1
        3'b101:  cmd = pin.gfx_sel ? SGD_C_UNDEF : SGD_C_READ; // RULE2
        3'b100:  cmd = pin.gfx_sel ? SGD_C_BW : SGD_C_STORE_BURST_CMD; // RULE3
        3'b011:  cmd = pin.gfx_sel ? SGD_C_ROW_OPEN_MASKED_CMD : SGD_C_ACT; // RULE4
        3'b010:  cmd = pin.gfx_sel ? SGD_C_UNDEF : SGD_C_PRE; // RULE5
        3'b001:  cmd = pin.gfx_sel ? SGD_C_UNDEF : SGD_C_REF;
        3'b000:  cmd = pin.gfx_sel ? SGD_C_SRS : SGD_C_MRS; // RULE6
        default: cmd = SGD_C_UNDEF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bank state machines and clock-enable modes
  // ----------------------------------------------------------------
  sgd_bank_t      st_reg [2];
  sgd_bank_t      st_next [2];
  logic [BL_W-1:0] cnt_reg [2];
  logic [BL_W-1:0] cnt_next [2];
  // Row is held per bank from row open, not taken from column-cycle address
  logic [ROW_W-1:0] row_reg [2];
  logic [ROW_W-1:0] row_next [2];
  logic [1:0]     wpb_reg, wpb_next;
  sgd_mode_t      mode_reg, mode_next;
  logic [3:0]     mcnt_reg, mcnt_next;
  logic           ill_next, mrs_next, srs_next, push;
  logic           both_idle, full_page, go;
  sgd_burst_t     burst_halt_cmd;
  logic           fifo_ready;
  logic [BL_W-1:0] bl;

  always_comb begin
    bl        = BL_W'(BURST_LEN);
    full_page = (BURST_LEN == BL_FULL);
    both_idle = (st_reg[0] == SGD_IDLE) && (st_reg[1] == SGD_IDLE);
    cke_prev_next = pin.cke;
    mode_next = mode_reg;
    mcnt_next = (mcnt_reg != '0) ? mcnt_reg - 4'h1 : mcnt_reg;
    wpb_next  = wpb_reg;
    ill_next  = 1'b0;
    mrs_next  = 1'b0;
    srs_next  = 1'b0;
    push      = 1'b0;
    go        = 1'b0;
    burst_halt_cmd = '{bank: sel_bank, is_write: 1'b0, is_block: 1'b0, auto_close: ap,
            col: pin.addr[COL_W-1:0], row: row_reg[sel_bank],
            lane_pass: ~pin.lane_mask}; // RULE7 RULE2
    for (int b = 0; b < 2; b++) begin
      st_next[b]  = st_reg[b];
      cnt_next[b] = cnt_reg[b];
      row_next[b] = row_reg[b];
    end
    unique case (mode_reg)
      SGD_M_SUSPEND: if (pin.cke) mode_next = SGD_M_RUN; // RULE8
      SGD_M_PDOWN:   if (pin.cke) mode_next = SGD_M_RUN; // RULE9
      SGD_M_SELF: if (pin.cke) begin
        mode_next = SGD_M_REFRESH;
        mcnt_next = 4'(CNT_RC);
      end
      SGD_M_REFRESH, SGD_M_MRACC: begin
        if (mcnt_reg <= 4'h1) mode_next = SGD_M_RUN;
        if (!(cmd inside {SGD_C_CHIP_DESELECT, SGD_C_NOP})) ill_next = 1'b1;
      end
      SGD_M_RUN: go = cke_prev_reg;
    endcase
    // Bursts, timers run on valid edges and on every edge of refresh or mode-load access
    for (int b = 0; b < 2; b++) begin
      if (go || mode_reg inside {SGD_M_REFRESH, SGD_M_MRACC}) begin
        if (cnt_reg[b] != '0) cnt_next[b] = cnt_reg[b] - 1'b1;
        if (cnt_reg[b] <= BL_W'(1)) begin
          unique case (st_reg[b])
            SGD_READ, SGD_ACTIVATING, SGD_WRREC: st_next[b] = SGD_ACTIVE; // RULE16
            SGD_READ_AP, SGD_WRREC_AP: begin // RULE23
              st_next[b] = SGD_PRECH;
              cnt_next[b] = BL_W'(CNT_RP);
            end
            SGD_WRITE: begin // RULE21
              st_next[b] = SGD_WRREC;
              cnt_next[b] = BL_W'(CNT_DPL);
            end
            SGD_WRITE_AP: begin // RULE22
              st_next[b] = SGD_WRREC_AP;
              cnt_next[b] = BL_W'(CNT_DPL);
            end
            SGD_PRECH: begin
              st_next[b] = SGD_IDLE;
              wpb_next[b] = 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
    if (go) begin
      if (!pin.cke) begin
        // Power down needs both banks idle; otherwise freeze in suspend
        mode_next = both_idle ? SGD_M_PDOWN : SGD_M_SUSPEND; // RULE8 RULE9
      end
      // RULE26 RULE27
      unique case (cmd)
        SGD_C_CHIP_DESELECT, SGD_C_NOP: ;
        SGD_C_UNDEF: ill_next = 1'b1;
        SGD_C_BST: begin // RULE18
          if (!(st_reg[sel_bank] inside {SGD_READ, SGD_WRITE})) ill_next = 1'b1;
          else if (full_page) begin
            st_next[sel_bank] = SGD_ACTIVE;
            cnt_next[sel_bank] = '0;
          end
        end
        SGD_C_READ, SGD_C_STORE_BURST_CMD, SGD_C_BW: begin
          if (st_reg[sel_bank] inside {SGD_ACTIVE, SGD_READ, SGD_WRITE, SGD_WRREC}) begin
            // RULE14 RULE15 RULE16 RULE17 RULE21 RULE25
            burst_halt_cmd.is_write = (cmd != SGD_C_READ);
            burst_halt_cmd.is_block = (cmd == SGD_C_BW); // RULE3
            push = 1'b1;
            if (cmd == SGD_C_READ) st_next[sel_bank] = ap ? SGD_READ_AP : SGD_READ;
            else st_next[sel_bank] = ap ? SGD_WRITE_AP : SGD_WRITE;
            // Block write is always a single beat
            cnt_next[sel_bank] = (cmd == SGD_C_BW) ? BL_W'(1) : bl;
          end else begin
            ill_next = 1'b1; // RULE12 RULE22 RULE23
          end
        end
        SGD_C_ACT, SGD_C_ROW_OPEN_MASKED_CMD: begin
          if (st_reg[sel_bank] == SGD_IDLE) begin // RULE10 RULE11
            st_next[sel_bank]  = SGD_ACTIVATING;
            cnt_next[sel_bank] = BL_W'(CNT_RCD);
            wpb_next[sel_bank] = (cmd == SGD_C_ROW_OPEN_MASKED_CMD); // RULE4
            row_next[sel_bank] = pin.addr[ROW_W-1:0]; // RULE4
            burst_halt_cmd.is_write = 1'b0;
          end else begin
            ill_next = 1'b1;
          end
        end
        SGD_C_PRE: begin // RULE5
          for (int b = 0; b < 2; b++) begin
            if (ap || sel_bank == b[0]) begin
              unique case (st_reg[b])
                SGD_IDLE, SGD_PRECH: ; // RULE10
                SGD_ACTIVE, SGD_READ: begin // RULE19
                  st_next[b] = SGD_PRECH;
                  cnt_next[b] = BL_W'(CNT_RP);
                end
                SGD_WRITE: begin // RULE20
                  st_next[b] = SGD_PRECH;
                  cnt_next[b] = BL_W'(CNT_RP + CNT_DPL);
                end
                default: ill_next = 1'b1; // RULE25
              endcase
            end
          end
        end
        SGD_C_REF: begin // RULE12
          if (!both_idle) ill_next = 1'b1;
          else if (pin.cke) begin
            mode_next = SGD_M_REFRESH;
            mcnt_next = 4'(CNT_RC);
          end else begin
            mode_next = SGD_M_SELF;
          end
        end
        SGD_C_MRS: begin // RULE13
          if (!both_idle) ill_next = 1'b1;
          else begin
            mrs_next  = 1'b1;
            mode_next = SGD_M_MRACC;
            mcnt_next = 4'(CNT_RSC);
          end
        end
        SGD_C_SRS: begin // RULE24
          if (st_reg[sel_bank] inside {SGD_IDLE, SGD_ACTIVE, SGD_ACTIVATING,
                                       SGD_WRREC, SGD_PRECH}) srs_next = 1'b1;
          else ill_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int b = 0; b < 2; b++) begin
        st_reg[b]  <= SGD_IDLE;
        cnt_reg[b] <= '0;
        row_reg[b] <= '0;
      end
      wpb_reg        <= BANKS_IDLE_RST;
      mode_reg       <= SGD_M_RUN;
      mcnt_reg       <= '0;
      cke_prev_reg   <= 1'b0;
      o_illegal      <= 1'b0;
      o_mode_load    <= 1'b0;
      o_color_load   <= 1'b0;
      o_opcode       <= '0;
      o_lane_pass    <= '1;
      o_bank_open    <= '0;
      o_bit_mask_en  <= '0;
      o_suspend      <= 1'b0;
      o_power_down   <= 1'b0;
      o_self_refresh <= 1'b0;
      o_cmd_stall    <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        st_reg[b]  <= st_next[b];
        cnt_reg[b] <= cnt_next[b];
        row_reg[b] <= row_next[b];
        o_bank_open[b] <= st_next[b] != SGD_IDLE;
      end
      wpb_reg        <= wpb_next;
      mode_reg       <= mode_next;
      mcnt_reg       <= mcnt_next;
      cke_prev_reg   <= cke_prev_next;
      o_illegal      <= ill_next;
      o_mode_load    <= mrs_next;
      o_color_load   <= srs_next;
      o_opcode       <= pin.addr;
      o_lane_pass    <= ~pin.lane_mask; // RULE7
      o_bit_mask_en  <= wpb_next;
      o_suspend      <= mode_next == SGD_M_SUSPEND;
      o_power_down   <= mode_next == SGD_M_PDOWN;
      o_self_refresh <= mode_next == SGD_M_SELF;
      o_cmd_stall    <= !fifo_ready;
    end
  end

  // ----------------------------------------------------------------
  // Column command queue
  // ----------------------------------------------------------------
  logic              q_valid;
  logic [FIFO_W-1:0] q_data;
  logic              out_valid_reg;
  logic [FIFO_W-1:0] out_data_reg;

  sgd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (FIFO_W'(burst_halt_cmd)),
    .o_out_valid (q_valid),
    .i_out_ready (i_burst_ready && !out_valid_reg),
    .o_out_data  (q_data)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (!out_valid_reg || i_burst_ready) begin
      out_valid_reg <= q_valid && i_burst_ready && !out_valid_reg;
      out_data_reg  <= q_data;
    end
  end

  assign o_burst_valid = out_valid_reg;
  assign o_burst_data  = out_data_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mrs_idle;
    @(posedge i_clk_sys) disable iff (i_rst)
    o_mode_load |-> $past(both_idle);
  endproperty
  a_mrs_idle: assert property (p_mrs_idle) else $error("mode load while bank open"); // RULE13

  property p_act;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && cmd == SGD_C_ACT && st_reg[sel_bank] == SGD_IDLE)
      |=> st_reg[$past(sel_bank)] == SGD_ACTIVATING;
  endproperty
  a_act: assert property (p_act) else $error("row open did not activate"); // RULE10

  property p_close_all_banks_cmd;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && cmd == SGD_C_PRE && ap && st_reg[0] == SGD_ACTIVE && st_reg[1] == SGD_ACTIVE)
      |=> st_reg[0] == SGD_PRECH && st_reg[1] == SGD_PRECH;
  endproperty
  a_close_all_banks_cmd: assert property (p_close_all_banks_cmd) else $error("close all missed a bank"); // RULE5

  property p_lane;
    @(posedge i_clk_sys) disable iff (i_rst)
    1'b1 |=> o_lane_pass == ~$past(pin.lane_mask);
  endproperty
  a_lane: assert property (p_lane) else $error("lane pass wrong"); // RULE7

  property p_susp;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && !pin.cke && !both_idle) |=> o_suspend;
  endproperty
  a_susp: assert property (p_susp) else $error("no clock suspend"); // RULE8

  property p_pd;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && !pin.cke && both_idle && cmd != SGD_C_REF) |=> o_power_down;
  endproperty
  a_pd: assert property (p_pd) else $error("no power down"); // RULE9

  property p_col_idle;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && cmd == SGD_C_READ && st_reg[sel_bank] == SGD_IDLE) |=> o_illegal;
  endproperty
  a_col_idle: assert property (p_col_idle) else $error("idle fetch not flagged"); // RULE12

  property p_wpb;
    @(posedge i_clk_sys) disable iff (i_rst)
    (go && cmd == SGD_C_ROW_OPEN_MASKED_CMD && st_reg[sel_bank] == SGD_IDLE) |=> ##1 o_bit_mask_en != 2'h0;
  endproperty
  a_wpb: assert property (p_wpb) else $error("mask write not enabled"); // RULE11
endmodule

// ===== sim/sgd_ctrl_model.sv
// Controller model that drives the decoder's command pins and queue ready
`timescale 1ns/100ps
module sgd_ctrl_model
  import sgd_pkg::*;
(
  input  wire logic              i_clk_sys,
  output logic                   o_cs_n,
  output logic                   o_ras_n,
  output logic                   o_cas_n,
  output logic                   o_we_n,
  output logic                   o_gfx_sel,
  output logic                   o_cke,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [LANES-1:0]       o_lane_mask,
  output logic                   o_burst_ready
);
  // ----------------------------------------------------------------
  // Pin codes {cs_n, ras_n, cas_n, we_n, gfx_sel}
  // ----------------------------------------------------------------
  localparam logic [4:0] C_CHIP_DESELECT = 5'h1e;
  localparam logic [4:0] C_NOP  = 5'h0e;
  localparam logic [4:0] C_BST  = 5'h0c;
  localparam logic [4:0] C_READ = 5'h0a;
  localparam logic [4:0] C_STORE_BURST_CMD = 5'h08;
  localparam logic [4:0] C_BW   = 5'h09;
  localparam logic [4:0] C_ACT  = 5'h06;
  localparam logic [4:0] C_ACTW = 5'h07;
  localparam logic [4:0] C_PRE  = 5'h04;
  localparam logic [4:0] C_REF  = 5'h02;
  localparam logic [4:0] C_MRS  = 5'h00;
  localparam logic [4:0] C_SRS  = 5'h01;
  logic stall = 1'b0;
  assign o_burst_ready = ~stall;
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_gfx_sel} = C_CHIP_DESELECT;
    o_cke       = 1'b1;
    o_addr      = '0;
    o_lane_mask = '0;
  end
  // One command cycle, then no-op; clock enable stays as given
  task automatic cmd(input logic [4:0] c, input logic [ADDR_W-1:0] a, input logic k,
                     input logic [LANES-1:0] m);
    @(posedge i_clk_sys);
    #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_gfx_sel} = c;
    o_addr      = a;
    o_cke       = k;
    o_lane_mask = m;
    @(posedge i_clk_sys);
    #1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_gfx_sel} = C_NOP;
    o_addr = ~a; // Stale address never looks valid
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the two-bank command decoder
`timescale 1ns/100ps
module testbench;
  import sgd_pkg::*;
  localparam int FW = $bits(sgd_burst_t);
  logic i_clk_sys = 1'b0, i_rst = 1'b1;
  logic i_cs_n, i_ras_n, i_cas_n, i_we_n, i_gfx_sel, i_cke, i_burst_ready;
  logic [ADDR_W-1:0] i_addr, o_opcode, opc;
  logic [LANES-1:0]  i_lane_mask, o_lane_pass;
  logic o_burst_valid, o_illegal, o_suspend, o_power_down, o_self_refresh;
  logic o_mode_load, o_color_load, o_cmd_stall;
  logic [FW-1:0] o_burst_data, bdat;
  logic [1:0] o_bank_open, o_bit_mask_en;
  logic [3:0] seen;
  int error_cnt = 0, n_tests = 0, n;
  always #12.5 i_clk_sys = ~i_clk_sys;
  sgd_ctrl_model m0 (.i_clk_sys, .o_cs_n(i_cs_n), .o_ras_n(i_ras_n), .o_cas_n(i_cas_n),
    .o_we_n(i_we_n), .o_gfx_sel(i_gfx_sel), .o_cke(i_cke), .o_addr(i_addr),
    .o_lane_mask(i_lane_mask), .o_burst_ready(i_burst_ready));
  sgd_decoder #(.FIFO_W(FW)) dut (.i_clk_sys, .i_rst, .i_cs_n, .i_ras_n, .i_cas_n,
    .i_we_n, .i_gfx_sel, .i_cke, .i_addr, .i_lane_mask, .i_burst_ready, .o_burst_valid,
    .o_burst_data, .o_bank_open, .o_bit_mask_en, .o_illegal, .o_suspend, .o_power_down,
    .o_self_refresh, .o_mode_load, .o_color_load, .o_opcode, .o_lane_pass, .o_cmd_stall);
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [FW-1:0] e, input logic [FW-1:0] s);
    n_tests++;
    if (e !== s) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Pulses {illegal, mode, color, burst} gathered over the answer window
  task automatic go(input logic [4:0] c, input logic [9:0] a, input logic k = 1'b1,
                    input logic [3:0] m = 4'h0);
    m0.cmd(c, a, k, m);
    seen = '0;
    repeat (7) begin
      @(posedge i_clk_sys);
      #1;
      seen |= {o_illegal, o_mode_load, o_color_load, o_burst_valid & i_burst_ready};
      if (o_burst_valid && i_burst_ready) bdat = o_burst_data;
      if (o_mode_load || o_color_load) opc = o_opcode;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle;
    chk("open_rst", 2'h0, o_bank_open);
    go(m0.C_PRE, 10'h100); chk("pre_idle", 4'h0, seen);
    go(m0.C_READ, 10'h005); chk("rd_idle", 4'h8, seen);
    go(m0.C_BST, 10'h0); chk("bst_idle", 4'h8, seen);
    go(m0.C_MRS, 10'h2a5); chk("mrs", 4'h4, seen);
    chk("mrs_op", 10'h2a5, opc);
    go(m0.C_SRS, 10'h133); chk("srs", 4'h2, seen);
    chk("srs_op", 10'h133, opc);
  endtask
  task automatic t_open;
    go(m0.C_ACT, 10'h0c3); chk("act0", 2'h1, o_bank_open);
    chk("wpb0", 2'h0, o_bit_mask_en);
    go(m0.C_ACTW, 10'h27e); chk("act1", 2'h3, o_bank_open);
    chk("wpb1", 2'h2, o_bit_mask_en);
    go(m0.C_ACT, 10'h0c3); chk("act_act", 4'h8, seen);
    go(m0.C_MRS, 10'h0); chk("mrs_act", 4'h8, seen);
    go(m0.C_SRS, 10'h1); chk("srs_act", 4'h2, seen);
  endtask
  task automatic t_burst;
    go(m0.C_READ, 10'h05a, 1'b1, 4'h6); chk("rd", 4'h1, seen);
    chk("rd_word", {4'h0, 8'h5a, 9'h0c3, 4'h9}, bdat);
    chk("lanes", 4'h9, o_lane_pass);
    m0.cmd(m0.C_READ, 10'h011, 1'b1, 4'h0);
    go(m0.C_BST, 10'h0); chk("bst_rd", 4'h1, seen);
    m0.cmd(m0.C_READ, 10'h011, 1'b1, 4'h0);
    go(m0.C_STORE_BURST_CMD, 10'h022); chk("rd_wr", {4'h4, 8'h22, 9'h0c3, 4'hf}, bdat);
    chk("wr_done", 2'h3, o_bank_open);
    go(m0.C_BW, 10'h344); chk("bw", {4'hf, 8'h44, 9'h07e, 4'hf}, bdat);
    repeat (20) @(posedge i_clk_sys);
    #1 chk("bwa_close", 2'h1, o_bank_open);
    go(m0.C_READ, 10'h111); repeat (20) @(posedge i_clk_sys);
    #1 chk("rda_close", 2'h0, o_bank_open);
  endtask
  task automatic t_close;
    go(m0.C_ACT, 10'h0c3); go(m0.C_ACT, 10'h27e);
    go(m0.C_PRE, 10'h200); chk("pre_b1", 2'h1, o_bank_open);
    go(m0.C_ACT, 10'h27e);
    go(m0.C_PRE, 10'h100); chk("pre_all", 2'h0, o_bank_open);
  endtask
  task automatic t_cke;
    go(m0.C_ACT, 10'h0c3);
    go(m0.C_NOP, 10'h0, 1'b0); chk("susp", 1'b1, o_suspend);
    go(m0.C_NOP, 10'h0); chk("susp_x", 1'b0, o_suspend);
    go(m0.C_PRE, 10'h100);
    go(m0.C_NOP, 10'h0, 1'b0); chk("pdown", 1'b1, o_power_down);
    go(m0.C_NOP, 10'h0); chk("pdown_x", 1'b0, o_power_down);
    go(m0.C_REF, 10'h0, 1'b0); chk("self", 1'b1, o_self_refresh);
    go(m0.C_NOP, 10'h0); chk("self_x", 1'b0, o_self_refresh);
  endtask
  // Queue filled past depth while the consumer stalls, then drained
  task automatic t_fifo;
    repeat (8) @(posedge i_clk_sys);
    go(m0.C_ACT, 10'h0c3);
    m0.stall = 1'b1;
    repeat (5) m0.cmd(m0.C_READ, 10'h010, 1'b1, 4'h0);
    repeat (8) @(posedge i_clk_sys);
    #1 chk("q_full", 1'b1, o_cmd_stall);
    m0.stall = 1'b0;
    n = 0;
    repeat (20) begin
      @(posedge i_clk_sys);
      #1 n += int'(o_burst_valid);
    end
    chk("q_drain", 4, n);
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    t_idle();
    t_open();
    t_burst();
    t_close();
    t_cke();
    t_fifo();
    tally_and_finish();
  end
  initial begin
    #(25 * 5000);
    error_cnt++;
    tally_and_finish();
  end
endmodule
